/* rtl/i2c_seq_pkg.sv */
// Shared constants and types for the byte-level I2C transfer sequencer.
// Assumes a system clock domain plus the falling edge of the bus clock.
package i2c_seq_pkg;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Bit counter value of the eighth bit of a byte
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;
  // Header bit that follows the first one on the wire
  localparam logic [2:0] HDR_SECOND = 3'h6;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] RST_PIPE_RST = 2'h0;

  // ************************************************************
  // Synchroniser slots
  // ************************************************************
  localparam int SYS_SYNC_W = 5;
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_TGL = 2;
  localparam int SYN_ADDR = 3;
  localparam int SYN_STOP = 4;
  localparam int LINK_SYNC_W = 2;
  localparam int LSY_ACK = 0;
  localparam int LSY_ARB = 1;

  // ************************************************************
  // Transfer states
  // ************************************************************
  typedef enum logic [2:0] {
    idle_state,
    header_state,
    header_ack_state,
    receive_byte_state,
    data_ack_state,
    transmit_byte_state,
    wait_ack_state,
    stop_state
  } xfer_state_type;

endpackage

/* rtl/sync_bit.sv */
// Two-flop level synchroniser for one bit.
// Assumes the caller picks the clock edge by the clock it connects.
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  // First stage, read only by the second
  logic meta_r;

  // Two stages in series
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

/* rtl/i2c_transfer_sequencer.sv */
// Byte-level I2C transfer sequencer with start/stop watch and status flags.
// Assumes an external SCL/START/STOP generator and arbitration checker;
// the microcontroller side is a set of plain level and pulse ports on clk_sys.
//
// Contract
// - Sequencer logic runs on falling bus clock
// - START detected moves idle to header capture
// - Master drives header, captures eight bits
// - Header not acknowledged as master gives stop
// - Header lowest bit picks receive or transmit
// - Address match in header acknowledge: slave, flag
// - Slave drives header acknowledge, picks direction
// - Receive byte, then drive acknowledge bit
// - Receive and acknowledge alternate until STOP
// - Transmit byte, await acknowledge, repeat or stop
// - Every byte sets complete flag, maybe interrupt
// - Data exchanged in acknowledge slot, no stall
// - Stop state requests STOP as master, then idle
// - Bus busy from START until STOP
// - Arbitration loss: flag, slave mode, clear select
`timescale 1ns/1ps
`default_nettype none
module i2c_transfer_sequencer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_link_clk,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [6:0] own_slave_address,
  input wire logic ack_drive_bit,
  input wire logic master_select_wr,
  input wire logic master_select_wdata,
  output logic master_select_bit,
  input wire logic byte_data_wr,
  input wire logic [7:0] byte_data_wdata,
  output logic [7:0] byte_data_reg,
  input wire logic arb_lost_evt,
  input wire logic arbitration_lost_clr,
  input wire logic transfer_complete_clr,
  input wire logic int_enable,
  output logic transfer_complete_flag,
  output logic arbitration_lost_flag,
  output logic addressed_as_slave_flag,
  output logic bus_busy,
  output logic irq_out,
  output logic gen_stop_req
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_pipe_r; // Reset release pipeline
  logic rst_sync_n; // Released reset for the system domain

  // Release reset through two flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_r <= i2c_seq_pkg::RST_PIPE_RST;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe_r[1];

  // ************************************************************
  // Crossings into the system domain
  // ************************************************************
  logic [i2c_seq_pkg::SYS_SYNC_W-1:0] sys_async; // Raw levels
  logic [i2c_seq_pkg::SYS_SYNC_W-1:0] sys_sync; // Synchronised levels
  // Link-domain flops read from the system side
  logic xfer_tgl_r;
  logic addressed_r;
  logic stop_req_r;
  logic [7:0] link_rx_r;

  // Pins cross inverted, so the synchroniser's reset value reads as idle high
  // and no false START or STOP follows reset
  assign sys_async[i2c_seq_pkg::SYN_SCL] = ~scl_link_clk;
  assign sys_async[i2c_seq_pkg::SYN_SDA] = ~sda_in;
  assign sys_async[i2c_seq_pkg::SYN_TGL] = xfer_tgl_r;
  assign sys_async[i2c_seq_pkg::SYN_ADDR] = addressed_r;
  assign sys_async[i2c_seq_pkg::SYN_STOP] = stop_req_r;

  // One synchroniser per crossing level
  genvar gi;
  generate
    for (gi = 0; gi < i2c_seq_pkg::SYS_SYNC_W; gi++)
    begin : g_sys_sync
      sync_bit u_sync (
        .clk(clk_sys),
        .rst_n(rst_sync_n),
        .d(sys_async[gi]),
        .q(sys_sync[gi])
      );
    end
  endgenerate

  // ************************************************************
  // System domain: bus watch and status
  // ************************************************************
  logic scl_q_r; // Previous synced SCL
  logic sda_q_r; // Previous synced SDA
  logic tgl_q_r; // Previous synced byte toggle
  logic start_pend_r; // START seen, first falling SCL not yet seen
  logic mode_cap_r; // Master select captured at START
  logic arb_frame_r; // Arbitration lost within this frame
  logic link_rst_n_r; // Link-domain reset, low on STOP
  logic [7:0] tx_hold_r; // Byte written by the microcontroller
  logic master_sel_r;
  logic busy_r;
  logic arb_flag_r;
  logic tc_flag_r;
  logic irq_r;
  logic [7:0] rx_byte_r;

  // Edge decode on synced pins
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic tgl_edge;
  logic start_pend_nxt;
  logic master_sel_nxt;
  logic arb_flag_nxt;
  logic tc_flag_nxt;
  logic busy_nxt;
  logic scl_s; // Synced SCL, true level
  logic sda_s; // Synced SDA, true level
  assign scl_s = ~sys_sync[i2c_seq_pkg::SYN_SCL];
  assign sda_s = ~sys_sync[i2c_seq_pkg::SYN_SDA];
  assign start_det = scl_s & sda_q_r & ~sda_s;
  assign stop_det = scl_s & ~sda_q_r & sda_s;
  assign scl_fall = scl_q_r & ~scl_s;
  assign tgl_edge = sys_sync[i2c_seq_pkg::SYN_TGL] ^ tgl_q_r;
  // Pending START survives until the sequencer has had its first edge
  assign start_pend_nxt = start_det | (start_pend_r & ~scl_fall & ~stop_det);
  assign master_sel_nxt = arb_lost_evt ? 1'b0 :
                          (master_select_wr ? master_select_wdata : master_sel_r);
  // Set wins over clear on both sticky flags
  assign arb_flag_nxt = arb_lost_evt | (arb_flag_r & ~arbitration_lost_clr);
  assign tc_flag_nxt = tgl_edge | (tc_flag_r & ~transfer_complete_clr);
  assign busy_nxt = start_det | (busy_r & ~stop_det);

  // Pin history and toggle history
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      tgl_q_r <= 1'b0;
    end
    else
    begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      tgl_q_r <= sys_sync[i2c_seq_pkg::SYN_TGL];
    end
  end

  // Frame control handed to the link
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      start_pend_r <= 1'b0;
      mode_cap_r <= 1'b0;
      arb_frame_r <= 1'b0;
      link_rst_n_r <= 1'b0;
    end
    else
    begin
      start_pend_r <= start_pend_nxt;
      mode_cap_r <= start_det ? master_sel_r : mode_cap_r;
      arb_frame_r <= arb_lost_evt | (arb_frame_r & ~start_det);
      // A STOP ends the frame even though SCL makes no further edge
      link_rst_n_r <= ~stop_det;
    end
  end

  // Software-facing registers
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      master_sel_r <= 1'b0;
      busy_r <= 1'b0;
      arb_flag_r <= 1'b0;
      tc_flag_r <= 1'b0;
      irq_r <= 1'b0;
      tx_hold_r <= i2c_seq_pkg::DATA_RST;
      rx_byte_r <= i2c_seq_pkg::DATA_RST;
    end
    else
    begin
      master_sel_r <= master_sel_nxt;
      busy_r <= busy_nxt;
      arb_flag_r <= arb_flag_nxt;
      tc_flag_r <= tc_flag_nxt;
      irq_r <= tc_flag_nxt & int_enable;
      tx_hold_r <= byte_data_wr ? byte_data_wdata : tx_hold_r;
      rx_byte_r <= tgl_edge ? link_rx_r : rx_byte_r;
    end
  end

  assign master_select_bit = master_sel_r;
  assign bus_busy = busy_r;
  assign arbitration_lost_flag = arb_flag_r;
  assign transfer_complete_flag = tc_flag_r;
  assign irq_out = irq_r;
  assign byte_data_reg = rx_byte_r;
  assign addressed_as_slave_flag = sys_sync[i2c_seq_pkg::SYN_ADDR];
  assign gen_stop_req = sys_sync[i2c_seq_pkg::SYN_STOP];
  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  // ************************************************************
  // Link domain: falling edge of SCL
  // ************************************************************
  logic scl_n; // Inverted bus clock, so flops act on the falling edge
  logic [i2c_seq_pkg::LINK_SYNC_W-1:0] link_async;
  logic [i2c_seq_pkg::LINK_SYNC_W-1:0] link_sync;
  assign scl_n = ~scl_link_clk;
  assign link_async[i2c_seq_pkg::LSY_ACK] = ack_drive_bit;
  assign link_async[i2c_seq_pkg::LSY_ARB] = arb_frame_r;

  // Levels that may change mid-frame cross through two falling edges
  generate
    for (gi = 0; gi < i2c_seq_pkg::LINK_SYNC_W; gi++)
    begin : g_link_sync
      sync_bit u_sync (
        .clk(scl_n),
        .rst_n(link_rst_n_r),
        .d(link_async[gi]),
        .q(link_sync[gi])
      );
    end
  endgenerate

  i2c_seq_pkg::xfer_state_type state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt; // Bits finished in this byte
  logic [7:0] hdr_sr_r, hdr_sr_nxt; // Header capture
  logic [7:0] data_sr_r, data_sr_nxt; // Data shift
  logic [7:0] link_rx_nxt;
  logic sda_low_r, sda_low_nxt; // High pulls SDA low
  logic master_r, master_nxt;
  logic addressed_nxt;
  logic xfer_tgl_nxt;
  logic stop_req_nxt;

  // Decode of the current slot
  logic [7:0] hdr_shift;
  logic [7:0] data_shift;
  logic addr_match;
  logic last_bit;
  logic is_master;
  logic active;
  logic got_ack;
  logic tx_dir;
  logic hdr_bit;
  logic [2:0] hdr_idx;
  assign hdr_shift = {hdr_sr_r[6:0], sda_in};
  assign data_shift = {data_sr_r[6:0], sda_in};
  assign addr_match = (hdr_shift[7:1] == own_slave_address);
  assign last_bit = (bit_cnt_r == i2c_seq_pkg::BIT_LAST);
  // Arbitration loss drops master mode as soon as it is synced
  assign is_master = master_r & ~link_sync[i2c_seq_pkg::LSY_ARB];
  assign active = is_master | addressed_r;
  assign got_ack = ~sda_in;
  // direction from the header lowest bit
  assign tx_dir = is_master ? ~hdr_sr_r[0] : hdr_sr_r[0];
  assign hdr_idx = i2c_seq_pkg::HDR_SECOND - bit_cnt_r;
  assign hdr_bit = tx_hold_r[hdr_idx];

  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    hdr_sr_nxt = hdr_sr_r;
    data_sr_nxt = data_sr_r;
    link_rx_nxt = link_rx_r;
    sda_low_nxt = 1'b0;
    master_nxt = is_master;
    addressed_nxt = addressed_r;
    xfer_tgl_nxt = xfer_tgl_r;
    // START from any master, any state
    if (start_pend_r)
    begin
      state_nxt = i2c_seq_pkg::header_state;
      bit_cnt_nxt = i2c_seq_pkg::BIT_FIRST;
      master_nxt = mode_cap_r;
      addressed_nxt = 1'b0;
      sda_low_nxt = mode_cap_r & ~tx_hold_r[7];
    end
    else
    begin
      unique case (state_r)
        i2c_seq_pkg::idle_state:
        begin
          state_nxt = i2c_seq_pkg::idle_state;
        end
        i2c_seq_pkg::header_state:
        begin
          hdr_sr_nxt = hdr_shift;
          if (last_bit)
          begin
            state_nxt = i2c_seq_pkg::header_ack_state;
            // slave acknowledges by the ack bit
            if (addr_match && !is_master)
            begin
              addressed_nxt = 1'b1;
              sda_low_nxt = link_sync[i2c_seq_pkg::LSY_ACK];
            end
          end
          else
          begin
            bit_cnt_nxt = bit_cnt_r + i2c_seq_pkg::BIT_STEP;
            sda_low_nxt = is_master & ~hdr_bit;
          end
        end
        i2c_seq_pkg::header_ack_state:
        begin
          bit_cnt_nxt = i2c_seq_pkg::BIT_FIRST;
          if (is_master && !got_ack)
            state_nxt = i2c_seq_pkg::stop_state;
          else if (!active)
            state_nxt = i2c_seq_pkg::idle_state;
          else if (tx_dir)
          begin
            state_nxt = i2c_seq_pkg::transmit_byte_state;
            data_sr_nxt = tx_hold_r;
            sda_low_nxt = ~tx_hold_r[7];
          end
          else
            state_nxt = i2c_seq_pkg::receive_byte_state;
          // Header completion is reported like any byte
          if (active)
          begin
            xfer_tgl_nxt = ~xfer_tgl_r;
            link_rx_nxt = hdr_sr_r;
          end
        end
        i2c_seq_pkg::receive_byte_state:
        begin
          data_sr_nxt = data_shift;
          if (last_bit)
          begin
            state_nxt = i2c_seq_pkg::data_ack_state;
            sda_low_nxt = active & link_sync[i2c_seq_pkg::LSY_ACK];
          end
          else
            bit_cnt_nxt = bit_cnt_r + i2c_seq_pkg::BIT_STEP;
        end
        i2c_seq_pkg::data_ack_state:
        begin
          state_nxt = i2c_seq_pkg::receive_byte_state;
          bit_cnt_nxt = i2c_seq_pkg::BIT_FIRST;
          // hand byte over in the slot
          link_rx_nxt = data_sr_r;
          xfer_tgl_nxt = ~xfer_tgl_r;
        end
        i2c_seq_pkg::transmit_byte_state:
        begin
          data_sr_nxt = data_shift;
          if (last_bit)
            state_nxt = i2c_seq_pkg::wait_ack_state;
          else
          begin
            bit_cnt_nxt = bit_cnt_r + i2c_seq_pkg::BIT_STEP;
            sda_low_nxt = active & ~data_sr_r[6];
          end
        end
        i2c_seq_pkg::wait_ack_state:
        begin
          bit_cnt_nxt = i2c_seq_pkg::BIT_FIRST;
          link_rx_nxt = data_sr_r;
          xfer_tgl_nxt = ~xfer_tgl_r;
          if (got_ack)
          begin
            state_nxt = i2c_seq_pkg::transmit_byte_state;
            data_sr_nxt = tx_hold_r;
            sda_low_nxt = active & ~tx_hold_r[7];
          end
          else
            state_nxt = i2c_seq_pkg::stop_state;
        end
        i2c_seq_pkg::stop_state:
        begin
          state_nxt = i2c_seq_pkg::idle_state;
        end
      endcase
    end
  end
  // request lasts while master sits in stop
  assign stop_req_nxt = (state_nxt == i2c_seq_pkg::stop_state) & master_nxt;

  // reset or STOP: idle, count cleared, SDA released
  always_ff @(posedge scl_n or negedge link_rst_n_r)
  begin
    if (!link_rst_n_r)
    begin
      state_r <= i2c_seq_pkg::idle_state;
      bit_cnt_r <= i2c_seq_pkg::BIT_FIRST;
      hdr_sr_r <= i2c_seq_pkg::DATA_RST;
      data_sr_r <= i2c_seq_pkg::DATA_RST;
      link_rx_r <= i2c_seq_pkg::DATA_RST;
      sda_low_r <= 1'b0;
      master_r <= 1'b0;
      addressed_r <= 1'b0;
      stop_req_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      hdr_sr_r <= hdr_sr_nxt;
      data_sr_r <= data_sr_nxt;
      link_rx_r <= link_rx_nxt;
      sda_low_r <= sda_low_nxt;
      master_r <= master_nxt;
      addressed_r <= addressed_nxt;
      stop_req_r <= stop_req_nxt;
    end
  end

  // Toggle kept outside the frame reset so no false edge appears
  always_ff @(posedge scl_n or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      xfer_tgl_r <= 1'b0;
    else
      xfer_tgl_r <= xfer_tgl_nxt;
  end

  assign sda_oe = sda_low_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_START_HEADER: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    start_pend_r |=> (state_r == i2c_seq_pkg::header_state) && (bit_cnt_r == 3'h0))
    else $error("START did not enter header capture");
  AST_HEADER_EIGHT: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (start_pend_r ##1 !start_pend_r [*8]) |=> (state_r == i2c_seq_pkg::header_ack_state))
    else $error("header not complete after eight bits");
  AST_NACK_STOP: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::header_ack_state && is_master && sda_in && !start_pend_r)
    |=> (state_r == i2c_seq_pkg::stop_state) && stop_req_r)
    else $error("unacknowledged header did not stop");
  AST_MASTER_READ: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::header_ack_state && is_master && !sda_in && hdr_sr_r[0]
     && !start_pend_r) |=> (state_r == i2c_seq_pkg::receive_byte_state) && !sda_oe)
    else $error("master read did not enter receive");
  AST_SLAVE_MATCH: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::header_state && last_bit && addr_match && !is_master
     && !start_pend_r) |=> addressed_r && !master_r
     && (sda_oe == $past(link_sync[i2c_seq_pkg::LSY_ACK])))
    else $error("address match not taken as slave");
  AST_RCV_ACK: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::receive_byte_state && last_bit && !start_pend_r)
    |=> (state_r == i2c_seq_pkg::data_ack_state) ##1
        (start_pend_r || state_r == i2c_seq_pkg::receive_byte_state))
    else $error("receive and acknowledge did not alternate");
  AST_TX_RELEASE: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::transmit_byte_state && last_bit && !start_pend_r)
    |=> (state_r == i2c_seq_pkg::wait_ack_state) && !sda_oe)
    else $error("transmit did not release SDA for acknowledge");
  AST_STOP_IDLE: assert property (
    @(posedge scl_n) disable iff (!link_rst_n_r)
    (state_r == i2c_seq_pkg::stop_state && !start_pend_r)
    |=> (state_r == i2c_seq_pkg::idle_state) && !stop_req_r)
    else $error("stop state did not return to idle");
  AST_BYTE_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    tgl_edge |=> transfer_complete_flag && (byte_data_reg == $past(link_rx_r)))
    else $error("byte completion not flagged");
  AST_BUSY: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (start_det |=> bus_busy) and (stop_det |=> !bus_busy))
    else $error("busy does not follow START and STOP");
  AST_ARB_LOSS: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    arb_lost_evt |=> arbitration_lost_flag && !master_select_bit)
    else $error("arbitration loss not handled");

endmodule
`default_nettype wire

/* bench/i2c_bus_model.sv */
// Far-side bus model: the bus clock and the other device's data pulls.
// Assumes the bench builds the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
  output logic scl,
  output logic pull_low,
  input wire logic sda_wire
);
  // ************************************************
  // Bus cycles
  // ************************************************
  // Clock stands high outside frames
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic start();
    #7 pull_low = 1'b1;
    #240;
  endtask
  // Data moves only while the clock is low, long enough
  // that the system side never sees it move with SCL high
  task automatic bit_cyc(input logic tx, output logic rx);
    scl = 1'b0;
    #90 pull_low = ~tx;
    #90 scl = 1'b1;
    #3 rx = sda_wire;
    #3;
  endtask
  // Nine bits, MSB first; a 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
      bit_cyc(tx[i], rx[i]);
  endtask
  task automatic stop();
    scl = 1'b0;
    #45 pull_low = 1'b1;
    #45 scl = 1'b1;
    #120 pull_low = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

/* bench/i2c_transfer_sequencer_tb.sv */
// Testbench for the transfer sequencer against a bus model.
// Assumes the far side drives SCL and plays master or slave; the bench plays the host.
`timescale 1ns/1ps
`default_nettype none
module i2c_transfer_sequencer_tb;
  // ************************************************
  // Signals
  // ************************************************
  localparam logic [6:0] own_addr = 7'h3A;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ack_drive_bit = 1'b0;
  logic master_select_wr = 1'b0;
  logic master_select_wdata = 1'b0;
  logic byte_data_wr = 1'b0;
  logic [7:0] byte_data_wdata = 8'h00;
  logic arb_lost_evt = 1'b0;
  logic arbitration_lost_clr = 1'b0;
  logic transfer_complete_clr = 1'b0;
  logic int_enable = 1'b0;
  logic sda_o, sda_oe, master_select_bit, transfer_complete_flag;
  logic arbitration_lost_flag, addressed_as_slave_flag, bus_busy;
  logic irq_out, gen_stop_req, scl, pull_low, one_bit;
  logic [7:0] byte_data_reg;
  logic [8:0] rx;
  wire sda_wire;
  int mismatches = 0;
  int num_checks = 0;
  // Wired-AND with pull-up
  assign sda_wire = !((sda_oe && !sda_o) || pull_low);
  always #20 clk_sys = ~clk_sys;
  i2c_transfer_sequencer u_i2c_transfer_sequencer (.clk_sys(clk_sys), .rstn(rstn),
    .scl_link_clk(scl), .sda_in(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
    .own_slave_address(own_addr), .ack_drive_bit(ack_drive_bit),
    .master_select_wr(master_select_wr), .master_select_wdata(master_select_wdata),
    .master_select_bit(master_select_bit), .byte_data_wr(byte_data_wr),
    .byte_data_wdata(byte_data_wdata), .byte_data_reg(byte_data_reg),
    .arb_lost_evt(arb_lost_evt), .arbitration_lost_clr(arbitration_lost_clr),
    .transfer_complete_clr(transfer_complete_clr), .int_enable(int_enable),
    .transfer_complete_flag(transfer_complete_flag),
    .arbitration_lost_flag(arbitration_lost_flag),
    .addressed_as_slave_flag(addressed_as_slave_flag), .bus_busy(bus_busy),
    .irq_out(irq_out), .gen_stop_req(gen_stop_req));
  i2c_bus_model u_i2c_bus_model (.scl(scl), .pull_low(pull_low), .sda_wire(sda_wire));
  // ************************************************
  // Helpers
  // ************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 21 us
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end
  // ************************************************
  // Scenarios
  // ************************************************
  initial
  begin
    tick(6);
    rstn <= 1'b1;
    tick(4);
    chk({sda_oe, transfer_complete_flag, arbitration_lost_flag, bus_busy,
      addressed_as_slave_flag, master_select_bit, irq_out, gen_stop_req, 1'b0}, 9'h000);
    chk({1'b0, byte_data_reg}, 9'h000);
    // Slave receive: header acked, first byte acked, last not
    ack_drive_bit <= 1'b1;
    u_i2c_bus_model.start();
    u_i2c_bus_model.xfer({own_addr, 1'b0, 1'b1}, rx);
    chk(rx, {own_addr, 1'b0, 1'b0});
    u_i2c_bus_model.xfer({8'h3C, 1'b1}, rx);
    chk(rx, {8'h3C, 1'b0});
    tick(2);
    chk({6'h00, bus_busy, addressed_as_slave_flag, transfer_complete_flag}, 9'h007);
    chk({1'b0, byte_data_reg}, {1'b0, own_addr, 1'b0});
    // host drops acknowledge before the last byte
    ack_drive_bit <= 1'b0;
    u_i2c_bus_model.xfer({8'hC3, 1'b1}, rx);
    chk(rx, {8'hC3, 1'b1});
    tick(2);
    chk({1'b0, byte_data_reg}, 9'h03C);
    u_i2c_bus_model.stop();
    tick(6);
    chk({7'h00, bus_busy, addressed_as_slave_flag}, 9'h000);
    chk({1'b0, byte_data_reg}, 9'h0C3);
    // Slave transmit: byte shifted out, master does not ack
    byte_data_wr <= 1'b1;
    byte_data_wdata <= 8'hA5;
    transfer_complete_clr <= 1'b1;
    ack_drive_bit <= 1'b1;
    tick(1);
    byte_data_wr <= 1'b0;
    transfer_complete_clr <= 1'b0;
    tick(1);
    u_i2c_bus_model.start();
    u_i2c_bus_model.xfer({own_addr, 1'b1, 1'b1}, rx);
    chk(rx, {own_addr, 1'b1, 1'b0});
    u_i2c_bus_model.xfer(9'h1FF, rx);
    chk(rx, {8'hA5, 1'b1});
    u_i2c_bus_model.stop();
    tick(4);
    chk({8'h00, transfer_complete_flag}, 9'h001);
    // Foreign address: nobody drives the acknowledge
    u_i2c_bus_model.start();
    u_i2c_bus_model.xfer({own_addr ^ 7'h01, 1'b0, 1'b1}, rx);
    chk({rx, addressed_as_slave_flag}, {own_addr ^ 7'h01, 1'b0, 1'b1, 1'b0});
    u_i2c_bus_model.stop();
    tick(1);
    // Master write: header driven, slave absent, stop requested
    master_select_wr <= 1'b1;
    master_select_wdata <= 1'b1;
    byte_data_wr <= 1'b1;
    byte_data_wdata <= 8'hA4;
    tick(1);
    master_select_wr <= 1'b0;
    byte_data_wr <= 1'b0;
    tick(1);
    u_i2c_bus_model.start();
    u_i2c_bus_model.xfer(9'h1FF, rx);
    chk(rx, {8'hA4, 1'b1});
    u_i2c_bus_model.bit_cyc(1'b1, one_bit);
    chk({8'h00, one_bit}, 9'h001);
    tick(4);
    chk({8'h00, gen_stop_req}, 9'h001);
    // host clears master select before the bus model sends STOP
    master_select_wr <= 1'b1;
    master_select_wdata <= 1'b0;
    tick(1);
    master_select_wr <= 1'b0;
    u_i2c_bus_model.stop();
    tick(6);
    chk({8'h00, gen_stop_req}, 9'h000);
    // Master read: slave acks header and sends a byte, host acks it
    master_select_wr <= 1'b1;
    master_select_wdata <= 1'b1;
    byte_data_wr <= 1'b1;
    byte_data_wdata <= 8'h51;
    tick(1);
    master_select_wr <= 1'b0;
    byte_data_wr <= 1'b0;
    tick(1);
    u_i2c_bus_model.start();
    u_i2c_bus_model.xfer(9'h1FE, rx);
    chk(rx, {8'h51, 1'b0});
    u_i2c_bus_model.xfer({8'h96, 1'b1}, rx);
    chk(rx, {8'h96, 1'b0});
    u_i2c_bus_model.stop();
    tick(6);
    chk({1'b0, byte_data_reg}, 9'h096);
    // Interrupt follows flag; arbitration loss drops select
    int_enable <= 1'b1;
    tick(3);
    chk({8'h00, irq_out}, 9'h001);
    master_select_wr <= 1'b1;
    master_select_wdata <= 1'b1;
    tick(1);
    master_select_wr <= 1'b0;
    arb_lost_evt <= 1'b1;
    tick(1);
    arb_lost_evt <= 1'b0;
    tick(1);
    chk({7'h00, arbitration_lost_flag, master_select_bit}, 9'h002);
    arbitration_lost_clr <= 1'b1;
    transfer_complete_clr <= 1'b1;
    tick(1);
    arbitration_lost_clr <= 1'b0;
    transfer_complete_clr <= 1'b0;
    tick(2);
    chk({6'h00, arbitration_lost_flag, transfer_complete_flag, irq_out}, 9'h000);
    finish_test();
  end
endmodule
`default_nettype wire
